// ---- hw/spf_framer.v ----
// one gateway serial port framer: receive block assembly and transmit
// assumes byte-wide character strobes from an external uart and
// a strobe register port with read data one cycle after the read strobe
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "spf_map.vh"
module spf_framer
#(
  parameter MS_CYCLES = `SPF_MS_CYCLES,
  parameter BUF_BYTES = `SPF_BUF_BYTES
)
(
  input wire MCLK,
  input wire RST_N,
  input wire [3:0] ADDR,
  input wire [15:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [15:0] RDATA,
  input wire [7:0] RX_CHAR,
  input wire RX_VALID,
  output reg [7:0] TX_CHAR,
  output reg TX_VALID,
  input wire TX_READY,
  output reg [7:0] STREAM_CHAR,
  output reg STREAM_VALID,
  output reg BLOCK_DONE
);
  //////////////////////////////////////////////////////////////////////
  // configuration registers, one set per port instance
  // nothing here is shared, so ports never see each other // RULE5
  reg [15:0] rx_base_q;
  reg [15:0] tx_base_q;
  reg [7:0] end_sel_q;
  reg [2:0] end_cnt_q;
  reg [31:0] end_chars_q;
  reg [15:0] msg_tmo_q;
  reg [15:0] gap_tmo_q;
  reg [7:0] blk_lim_q;
  reg [15:0] tx_seq_q;
  reg [15:0] tx_pace_q;
  reg [7:0] tx_len_q;
  reg [15:0] rx_seq_q;
  reg [7:0] rx_len_q;
  reg [7:0] tx_mem [0:BUF_BYTES-1];
  reg [7:0] rx_mem [0:BUF_BYTES-1];
  reg [7:0] tx_wp_q;
  reg [7:0] rx_rp_q;

  wire rx_on = (rx_base_q != `SPF_BASE_OFF); // RULE3
  wire tx_on = (tx_base_q != `SPF_BASE_OFF); // RULE2
  wire [3:0] sel = end_sel_q[3:0]; // RULE16
  wire stream_mode = (sel == 4'h0); // RULE8

  // matches a character against the first n end characters
  function is_end_char;
    input [7:0] c;
    input [31:0] list;
    input [2:0] n;
    integer i;
    begin
      is_end_char = 1'b0;
      for (i = 0; i < 4; i = i + 1)
        if ((i < n) && (list[8*i +: 8] == c))
          is_end_char = 1'b1;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // millisecond tick, shared by every timer of this port
  reg [31:0] tick_cnt_q;
  reg ms_tick_q;
  always @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tick_cnt_q <= 32'h00000000;
      ms_tick_q <= 1'b0;
    end
    else if (tick_cnt_q >= MS_CYCLES - 1)
    begin
      tick_cnt_q <= 32'h00000000;
      ms_tick_q <= 1'b1;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 32'h00000001;
      ms_tick_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // receive path state
  reg [7:0] rx_cnt_q;
  reg rx_busy_q;
  reg [31:0] rx_total_q;
  reg [15:0] msg_total_q;
  wire take = RX_VALID && rx_on && !stream_mode;
  wire msg_exp;
  wire gap_exp;
  wire hit_char = take && sel[`SPF_SEL_CHAR] &&
    is_end_char(RX_CHAR, end_chars_q, end_cnt_q); // RULE10
  wire hit_size = take && sel[`SPF_SEL_SIZE] &&
    (rx_cnt_q + 8'h01 >= blk_lim_q); // RULE13
  wire hit_full = take && (rx_cnt_q == BUF_BYTES - 1);
  wire hit_tmo = rx_busy_q && sel[`SPF_SEL_TMO] && msg_exp; // RULE11
  wire hit_gap = rx_busy_q && sel[`SPF_SEL_GAP] && gap_exp; // RULE12
  wire deliver = hit_char | hit_size | hit_full | hit_tmo | hit_gap; // RULE9

  // message timer only on the first character of a block
  spf_ms_timer u_msg
  (
    .MCLK(MCLK),
    .RST_N(RST_N),
    .start(take && !rx_busy_q), // RULE11
    .stop(deliver),
    .ms_load(msg_tmo_q),
    .ms_tick(ms_tick_q),
    .expired(msg_exp)
  );

  // gap timer reloads on every character
  spf_ms_timer u_gap
  (
    .MCLK(MCLK),
    .RST_N(RST_N),
    .start(take), // RULE12
    .stop(deliver && !take),
    .ms_load(gap_tmo_q),
    .ms_tick(ms_tick_q),
    .expired(gap_exp)
  );

  // buffering, delivery and the receive sequence word
  always @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rx_cnt_q <= 8'h00;
      rx_busy_q <= 1'b0;
      rx_seq_q <= 16'h0000;
      rx_len_q <= 8'h00;
      rx_total_q <= 32'h00000000;
      msg_total_q <= 16'h0000;
      BLOCK_DONE <= 1'b0;
      STREAM_VALID <= 1'b0;
      STREAM_CHAR <= 8'h00;
    end
    else
    begin
      BLOCK_DONE <= 1'b0;
      STREAM_VALID <= 1'b0;
      if (RX_VALID && rx_on)
        rx_total_q <= rx_total_q + 32'h00000001;
      if (RX_VALID && rx_on && stream_mode)
      begin
        STREAM_CHAR <= RX_CHAR; // RULE8
        STREAM_VALID <= 1'b1;
      end
      if (take)
        rx_mem[rx_cnt_q] <= RX_CHAR; // RULE6
      if (deliver)
      begin
        // the block copy is the length latch; data stays in rx_mem
        rx_len_q <= take ? rx_cnt_q + 8'h01 : rx_cnt_q;
        rx_seq_q <= rx_seq_q + 16'h0001; // RULE14
        msg_total_q <= msg_total_q + 16'h0001;
        BLOCK_DONE <= 1'b1;
        rx_cnt_q <= 8'h00;
        rx_busy_q <= 1'b0;
      end
      else if (take)
      begin
        rx_cnt_q <= rx_cnt_q + 8'h01; // RULE6
        rx_busy_q <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // transmit path: one-hot states
  localparam TX_IDLE = 3'b001;
  localparam TX_SEND = 3'b010;
  localparam TX_PACE = 3'b100;
  reg [2:0] tx_st_q;
  reg [15:0] tx_last_q;
  reg [7:0] tx_idx_q;
  reg [7:0] tx_sent_q;
  reg [31:0] tx_total_q;
  wire pace_exp;
  wire tx_go = tx_on && (tx_seq_q != tx_last_q) && (tx_st_q == TX_IDLE);
  wire tx_fire = (tx_st_q == TX_SEND) && TX_READY && !TX_VALID;

  // the shared tick can fall just after a send, so a bare load runs short
  // by up to one ms; one extra tick keeps the gap at least the word
  wire [15:0] pace_load = (tx_pace_q == 16'hFFFF) ? tx_pace_q :
    tx_pace_q + 16'h0001; // RULE15

  // pacing between characters; zero load never expires
  spf_ms_timer u_pace
  (
    .MCLK(MCLK),
    .RST_N(RST_N),
    .start(tx_fire),
    .stop(1'b0),
    .ms_load(pace_load),
    .ms_tick(ms_tick_q),
    .expired(pace_exp)
  );

  // sequence watch, character output and pacing
  always @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tx_st_q <= TX_IDLE;
      tx_last_q <= 16'h0000;
      tx_idx_q <= 8'h00;
      tx_sent_q <= 8'h00;
      tx_total_q <= 32'h00000000;
      TX_VALID <= 1'b0;
      TX_CHAR <= 8'h00;
    end
    else
    begin
      TX_VALID <= 1'b0;
      case (tx_st_q)
        TX_IDLE:
        begin
          if (tx_go) // RULE4
          begin
            tx_last_q <= tx_seq_q;
            tx_idx_q <= 8'h00;
            if (tx_len_q != 8'h00)
            begin
              tx_sent_q <= 8'h00;
              tx_st_q <= TX_SEND;
            end
          end
        end
        TX_SEND:
        begin
          if (!tx_on) // RULE1
            tx_st_q <= TX_IDLE;
          else if (tx_fire)
          begin
            TX_CHAR <= tx_mem[tx_idx_q];
            TX_VALID <= 1'b1;
            tx_idx_q <= tx_idx_q + 8'h01;
            tx_sent_q <= tx_sent_q + 8'h01;
            tx_total_q <= tx_total_q + 32'h00000001;
            if (tx_idx_q + 8'h01 >= tx_len_q)
              tx_st_q <= TX_IDLE;
            else if (tx_pace_q != 16'h0000)
              tx_st_q <= TX_PACE; // RULE15
          end
        end
        TX_PACE:
        begin
          if (!tx_on)
            tx_st_q <= TX_IDLE;
          else if (pace_exp)
            tx_st_q <= TX_SEND; // RULE15
        end
        default:
          tx_st_q <= TX_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // register writes; data ports auto-increment their pointers
  always @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rx_base_q <= `SPF_BASE_OFF;
      tx_base_q <= `SPF_BASE_OFF;
      end_sel_q <= 8'h00;
      end_cnt_q <= 3'h0;
      end_chars_q <= 32'h00000000;
      msg_tmo_q <= 16'h0000;
      gap_tmo_q <= 16'h0000;
      blk_lim_q <= 8'h00;
      tx_seq_q <= 16'h0000;
      tx_pace_q <= 16'h0000;
      tx_len_q <= 8'h00;
      tx_wp_q <= 8'h00;
      rx_rp_q <= 8'h00;
    end
    else
    begin
      if (RD && ADDR == `SPF_A_RX_DATA)
        rx_rp_q <= (rx_rp_q >= BUF_BYTES - 1) ? 8'h00 : rx_rp_q + 8'h01;
      if (WR)
      begin
        case (ADDR)
          `SPF_A_RX_BASE: rx_base_q <= WDATA;
          `SPF_A_TX_BASE: tx_base_q <= WDATA;
          `SPF_A_END_SEL: end_sel_q <= WDATA[7:0]; // RULE7
          `SPF_A_END_CNT: end_cnt_q <= WDATA[2:0];
          `SPF_A_END_CHARS: end_chars_q <= {end_chars_q[23:0], WDATA[7:0]};
          `SPF_A_MSG_TMO: msg_tmo_q <= WDATA;
          `SPF_A_GAP_TMO: gap_tmo_q <= WDATA;
          `SPF_A_BLK_LIM: blk_lim_q <= WDATA[7:0];
          `SPF_A_TX_SEQ: tx_seq_q <= WDATA;
          `SPF_A_TX_PACE: tx_pace_q <= WDATA;
          `SPF_A_TX_LEN: tx_len_q <= WDATA[7:0];
          `SPF_A_TX_DATA:
          begin
            tx_mem[tx_wp_q] <= WDATA[7:0];
            tx_wp_q <= (tx_wp_q >= BUF_BYTES - 1) ? 8'h00 : tx_wp_q + 8'h01;
          end
          `SPF_A_RX_DATA: rx_rp_q <= WDATA[7:0];
          `SPF_A_STATUS: tx_wp_q <= WDATA[7:0];
          default: tx_wp_q <= tx_wp_q;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read data, registered one cycle after the strobe
  always @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      RDATA <= 16'h0000;
    else if (RD)
    begin
      case (ADDR)
        `SPF_A_RX_BASE: RDATA <= rx_base_q;
        `SPF_A_TX_BASE: RDATA <= tx_base_q;
        `SPF_A_END_SEL: RDATA <= {8'h00, end_sel_q};
        `SPF_A_END_CNT: RDATA <= {13'h0000, end_cnt_q};
        `SPF_A_END_CHARS: RDATA <= end_chars_q[15:0];
        `SPF_A_MSG_TMO: RDATA <= msg_tmo_q;
        `SPF_A_GAP_TMO: RDATA <= gap_tmo_q;
        `SPF_A_BLK_LIM: RDATA <= {8'h00, blk_lim_q};
        `SPF_A_TX_SEQ: RDATA <= tx_seq_q;
        `SPF_A_TX_PACE: RDATA <= tx_pace_q;
        `SPF_A_TX_LEN: RDATA <= {tx_sent_q, tx_len_q};
        `SPF_A_RX_SEQ: RDATA <= rx_seq_q;
        `SPF_A_RX_LEN: RDATA <= {rx_cnt_q, rx_len_q};
        `SPF_A_STATUS: RDATA <= {msg_total_q[10:0], rx_busy_q, tx_st_q,
          tx_st_q != TX_IDLE};
        `SPF_A_RX_DATA: RDATA <= {8'h00, rx_mem[rx_rp_q]};
        default: RDATA <= 16'h0000;
      endcase
    end
    else
      RDATA <= 16'h0000;
  end
endmodule

// ---- hw/spf_map.vh ----
// register map, field positions and timing constants for the port framer
// assumes a 100 MHz clock and a plain strobe register port
// Behaviour
// RULE1: receive-only port never drives characters out
// RULE2: transmit base of minus one disables sending
// RULE3: receive base of minus one disables storing
// RULE4: send only when sequence number changes
// RULE5: each port runs on its own configuration
// RULE6: hold characters in 255-byte buffer until end
// RULE7: select bits: char, timeout, gap, size
// RULE8: select zero passes each character at once
// RULE9: any enabled condition delivers the block
// RULE10: deliver through matching end character
// RULE11: message timer starts on first character
// RULE12: gap timer restarts on every character
// RULE13: deliver each time size limit reached
// RULE14: bump receive sequence after each delivery
// RULE15: pacing word sets milliseconds between characters
// RULE16: reserved select bits are ignored
`ifndef SPF_MAP_VH
`define SPF_MAP_VH
`define SPF_A_RX_BASE 4'h0
`define SPF_A_TX_BASE 4'h1
`define SPF_A_END_SEL 4'h2
`define SPF_A_END_CNT 4'h3
`define SPF_A_END_CHARS 4'h4
`define SPF_A_MSG_TMO 4'h5
`define SPF_A_GAP_TMO 4'h6
`define SPF_A_BLK_LIM 4'h7
`define SPF_A_TX_SEQ 4'h8
`define SPF_A_TX_PACE 4'h9
`define SPF_A_TX_LEN 4'hA
`define SPF_A_RX_SEQ 4'hB
`define SPF_A_RX_LEN 4'hC
`define SPF_A_STATUS 4'hD
`define SPF_A_TX_DATA 4'hE
`define SPF_A_RX_DATA 4'hF
`define SPF_BASE_OFF 16'hFFFF
`define SPF_SEL_CHAR 0
`define SPF_SEL_TMO 1
`define SPF_SEL_GAP 2
`define SPF_SEL_SIZE 3
`define SPF_BUF_BYTES 255
`define SPF_MS_NS 1000000
`define SPF_CLK_NS 10
`define SPF_MS_CYCLES (`SPF_MS_NS / `SPF_CLK_NS)
`endif

// ---- hw/spf_ms_timer.v ----
// millisecond countdown timer used by the framer for gaps and pacing
// assumes a free-running millisecond tick from the framer top
`timescale 1ns/1ps
module spf_ms_timer
(
  input wire MCLK,
  input wire RST_N,
  input wire start,
  input wire stop,
  input wire [15:0] ms_load,
  input wire ms_tick,
  output reg expired
);
  reg [15:0] cnt_q;
  reg run_q;

  // counts ticks down; expired is a one-cycle pulse
  always @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cnt_q <= 16'h0000;
      run_q <= 1'b0;
      expired <= 1'b0;
    end
    else
    begin
      expired <= 1'b0;
      if (start)
      begin
        cnt_q <= ms_load;
        run_q <= (ms_load != 16'h0000);
      end
      else if (stop)
        run_q <= 1'b0;
      else if (run_q && ms_tick)
      begin
        if (cnt_q <= 16'h0001)
        begin
          run_q <= 1'b0;
          expired <= 1'b1;
        end
        else
          cnt_q <= cnt_q - 16'h0001;
      end
    end
  end
endmodule

// ---- sim/spf_chk.sv ----
// port assertions for the serial port framer
// bound to spf_framer from the testbench top file
`timescale 1ns/1ps
module spf_chk
(
  input wire MCLK,
  input wire RST_N,
  input wire WR,
  input wire [7:0] RX_CHAR,
  input wire RX_VALID,
  input wire TX_VALID,
  input wire [7:0] STREAM_CHAR,
  input wire STREAM_VALID,
  input wire BLOCK_DONE
);
  reg cfg_q;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////////////
  // until software writes, both bases still read as off
  always @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      cfg_q <= 1'b0;
    else if (WR)
      cfg_q <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////
  chk_tx_off_quiet: assert property (
    !cfg_q |-> !TX_VALID) else $error("send while transmit off");
  chk_rx_off_quiet: assert property (
    !cfg_q |-> !STREAM_VALID && !BLOCK_DONE)
    else $error("receive output while receive off");
  chk_tx_spacing: assert property (
    TX_VALID |=> !TX_VALID) else $error("characters sent back to back");
  chk_stream_pulse: assert property (
    STREAM_VALID |=> !STREAM_VALID) else $error("stream pulse too long");
  chk_stream_cause: assert property (
    STREAM_VALID |-> $past(RX_VALID)) else $error("stream without char");
  chk_stream_data: assert property (
    STREAM_VALID |-> STREAM_CHAR == $past(RX_CHAR))
    else $error("stream char differs from received");
  chk_done_pulse: assert property (
    BLOCK_DONE |=> !BLOCK_DONE) else $error("block done too long");
  chk_mode_excl: assert property (
    !(STREAM_VALID && BLOCK_DONE)) else $error("stream and block together");
endmodule

// ---- sim/spf_dev.sv ----
// serial device model: sends characters in, takes characters out
// assumes one-cycle character strobes on both sides
`timescale 1ns/1ps
module spf_dev
(
  input wire clk,
  input wire [7:0] tx_char,
  input wire tx_valid,
  output reg tx_ready,
  output reg [7:0] rx_char,
  output reg rx_valid
);
  reg [7:0] got [$];
  reg stall = 1'b0;
  initial
  begin
    tx_ready = 1'b1;
    rx_char = 8'h00;
    rx_valid = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // ready alternates while stalling, like a slow uart
  always @(posedge clk)
  begin
    tx_ready <= stall ? ~tx_ready : 1'b1;
    if (tx_valid)
      got.push_back(tx_char);
  end
  // idle line shows the inverse so stale data never looks valid
  task send(input [7:0] c, input integer gap);
  begin
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_char <= c;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_char <= ~c;
    repeat (gap) @(posedge clk);
  end
  endtask
endmodule

// ---- sim/spf_tb.sv ----
// self-checking bench for spf_framer with a serial device model
// assumes a 10 cycle millisecond so timers stay short
`timescale 1ns/1ps
`include "spf_map.vh"
module testbench;
  reg MCLK = 1'b0;
  reg RST_N = 1'b0;
  reg [3:0] ADDR = 4'h0;
  reg [15:0] WDATA = 16'h0000;
  reg WR = 1'b0;
  reg RD = 1'b0;
  wire [15:0] RDATA;
  wire [7:0] RX_CHAR, TX_CHAR, STREAM_CHAR;
  wire RX_VALID, TX_VALID, TX_READY, STREAM_VALID, BLOCK_DONE;
  integer fail_count = 0, total_checks = 0, seed = 32'h01cf6d30;
  integer cyc = 0, blk = 0, strm = 0, ntx = 0, last_tx = 0, min_gap = 999;
  integer i;
  reg [7:0] last_sc, c;
  reg [7:0] tx_exp [0:2];
  reg [15:0] v;
  string s = "ABC\015DE";
  always #5 MCLK = ~MCLK;
  spf_framer #(.MS_CYCLES(10), .BUF_BYTES(255)) u_spf_framer (.MCLK(MCLK),
    .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .RX_CHAR(RX_CHAR), .RX_VALID(RX_VALID),
    .TX_CHAR(TX_CHAR), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
    .STREAM_CHAR(STREAM_CHAR), .STREAM_VALID(STREAM_VALID),
    .BLOCK_DONE(BLOCK_DONE));
  spf_dev u_spf_dev (.clk(MCLK), .tx_char(TX_CHAR), .tx_valid(TX_VALID),
    .tx_ready(TX_READY), .rx_char(RX_CHAR), .rx_valid(RX_VALID));
  ////////////////////////////////////////////////////////////////////////
  // counts on the falling edge, clear of the launching edge
  always @(negedge MCLK)
  begin
    cyc = cyc + 1;
    if (BLOCK_DONE)
      blk = blk + 1;
    if (STREAM_VALID)
      strm = strm + 1;
    if (STREAM_VALID)
      last_sc = STREAM_CHAR;
    if (TX_VALID && cyc - last_tx < min_gap)
      min_gap = cyc - last_tx;
    if (TX_VALID)
      last_tx = cyc;
    if (TX_VALID)
      ntx = ntx + 1;
    if (cyc == 20000)
    begin
      fail_count = fail_count + 1;
      end_of_test;
    end
  end
  task chk(input string n, input [15:0] seen, input [15:0] e);
  begin
    total_checks = total_checks + 1;
    if (seen !== e)
    begin
      fail_count = fail_count + 1;
      $display("mismatch %s expected %h seen %h", n, e, seen);
    end
  end
  endtask
  task wr(input [3:0] a, input [15:0] d);
  begin
    @(posedge MCLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge MCLK);
    WR <= 1'b0;
  end
  endtask
  // read data stands only in the cycle after the strobe
  task rd(input [3:0] a);
  begin
    @(posedge MCLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge MCLK);
    RD <= 1'b0;
    @(negedge MCLK);
    v = RDATA;
  end
  endtask
  task burst(input integer n, input integer gap);
  begin
    for (i = 0; i < n; i = i + 1)
    begin
      c = $random(seed);
      u_spf_dev.send(c, gap);
    end
    @(negedge MCLK);
  end
  endtask
  task blocks(input [15:0] n, input [15:0] len);
  begin
    chk("blocks", blk[15:0], n);
    rd(`SPF_A_RX_SEQ);
    chk("rx seq", v, n);
    rd(`SPF_A_RX_LEN);
    chk("rx len", v & 16'h00FF, len);
  end
  endtask
  task end_of_test;
  begin
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // receive modes first, then the transmit path
  initial
  begin
    repeat (6) @(posedge MCLK);
    RST_N <= 1'b1;
    rd(`SPF_A_TX_BASE);
    chk("tx base", v, 16'hFFFF);
    burst(3, 2);
    blocks(16'h0000, 16'h0000);
    wr(`SPF_A_RX_BASE, 16'h0000);
    wr(`SPF_A_END_SEL, 16'h00F0);
    burst(1, 3);
    chk("stream n", strm[15:0], 16'h0001);
    chk("stream c", {8'h00, last_sc}, {8'h00, c});
    // size four: partial block held until filled
    wr(`SPF_A_BLK_LIM, 16'h0004);
    wr(`SPF_A_END_SEL, 16'h00F8);
    burst(10, 2);
    blocks(16'h0002, 16'h0004);
    burst(2, 2);
    blocks(16'h0003, 16'h0004);
    wr(`SPF_A_END_CNT, 16'h0001);
    wr(`SPF_A_END_CHARS, 16'h000D);
    wr(`SPF_A_END_SEL, 16'h0001);
    for (i = 0; i < 6; i = i + 1)
      u_spf_dev.send(s[i], 2);
    blocks(16'h0004, 16'h0004);
    burst(0, 0);
    u_spf_dev.send(8'h0D, 3);
    blocks(16'h0005, 16'h0003);
    // held block content: the two held chars, then the end char
    wr(`SPF_A_RX_DATA, 16'h0000);
    rd(`SPF_A_RX_DATA);
    chk("rx data 0", v, 16'h0044);
    rd(`SPF_A_RX_DATA);
    chk("rx data 1", v, 16'h0045);
    rd(`SPF_A_RX_DATA);
    chk("rx data 2", v, 16'h000D);
    // gap timer restarts: three close chars make one block
    wr(`SPF_A_GAP_TMO, 16'h0003);
    wr(`SPF_A_END_SEL, 16'h0004);
    burst(3, 10);
    chk("gap early", blk[15:0], 16'h0005);
    repeat (60) @(posedge MCLK);
    blocks(16'h0006, 16'h0003);
    // message timer runs from the first char, not the last
    wr(`SPF_A_MSG_TMO, 16'h0005);
    wr(`SPF_A_END_SEL, 16'h0002);
    burst(6, 18);
    repeat (40) @(posedge MCLK);
    blocks(16'h0008, 16'h0003);
    chk("no stream", strm[15:0], 16'h0001);
    wr(`SPF_A_TX_SEQ, 16'h0001);
    repeat (30) @(posedge MCLK);
    chk("rx only", ntx[15:0], 16'h0000);
    wr(`SPF_A_TX_BASE, 16'h0010);
    wr(`SPF_A_STATUS, 16'h0000);
    for (i = 0; i < 3; i = i + 1)
    begin
      tx_exp[i] = $random(seed);
      wr(`SPF_A_TX_DATA, {8'h00, tx_exp[i]});
    end
    wr(`SPF_A_TX_LEN, 16'h0003);
    u_spf_dev.stall = 1'b1;
    wr(`SPF_A_TX_SEQ, 16'h0002);
    repeat (60) @(posedge MCLK);
    for (i = 0; i < 3; i = i + 1)
      chk("tx c", {8'h00, u_spf_dev.got[i]}, {8'h00, tx_exp[i]});
    wr(`SPF_A_TX_SEQ, 16'h0002);
    repeat (40) @(posedge MCLK);
    chk("tx same seq", ntx[15:0], 16'h0003);
    // two millisecond pacing, far side ready
    u_spf_dev.stall = 1'b0;
    wr(`SPF_A_TX_PACE, 16'h0002);
    min_gap = 999;
    wr(`SPF_A_TX_SEQ, 16'h0003);
    repeat (120) @(posedge MCLK);
    chk("paced n", ntx[15:0], 16'h0006);
    chk("pace gap", {15'h0000, min_gap >= 20}, 16'h0001);
    wr(`SPF_A_TX_BASE, 16'hFFFF);
    wr(`SPF_A_TX_SEQ, 16'h0004);
    repeat (40) @(posedge MCLK);
    chk("tx off", ntx[15:0], 16'h0006);
    end_of_test;
  end
endmodule
bind spf_framer spf_chk u_spf_chk (.MCLK(MCLK), .RST_N(RST_N), .WR(WR),
  .RX_CHAR(RX_CHAR), .RX_VALID(RX_VALID), .TX_VALID(TX_VALID),
  .STREAM_CHAR(STREAM_CHAR), .STREAM_VALID(STREAM_VALID),
  .BLOCK_DONE(BLOCK_DONE));
